// File: hdl/fsp_page_buffer.sv
// Purpose: temporary page buffer filled word by word
// Assumes: clear and write never collide in a way that matters, clear wins
// Notes: erased words read as all ones
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buffer #(
    parameter int WORDS = 32,
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // fill side
    input wire logic wrEn,
    input wire logic [$clog2(WORDS)-1:0] wrIndex,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic clear,
    // drain side
    input wire logic [$clog2(WORDS)-1:0] rdIndex,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [WORDS];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= WIDTH'(fsp_pkg::ERASED_WORD);
            end
        end else if (clear) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= WIDTH'(fsp_pkg::ERASED_WORD);
            end
        end else if (wrEn) begin
            mem[wrIndex] <= wrData;
        end
    end

    assign rdData = mem[rdIndex];
endmodule // fsp_page_buffer
`default_nettype wire

// File: hdl/fsp_pkg.sv
// Purpose: shared constants and types of the flash self-program sequencer
// Assumes: 100 MHz mclk, 8-bit control register on a plain register port
// Notes: command patterns cover the low five control bits
package fsp_pkg;
    // register map
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // command patterns, low five control bits
    localparam logic [4:0] CMD_MASK = 5'h1F;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_LOCK = 5'h09;
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    // arming windows in cycles after the control write
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    // pointer layout
    localparam int WORD_LSB = 1;
    localparam int WORD_BITS = 5;
    localparam int PAGE_LSB = 6;
    localparam int PAGE_BITS = 10;
    // fuse read pointer values
    localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
    localparam logic [15:0] Z_LOCK = 16'h0001;
    localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    // values
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [5:0] LOCK_CLEAR_MASK = 6'h00;
    localparam logic [1:0] LOCK_TOP_BITS = 2'h3;
    localparam logic [7:0] BLOCKED_BYTE = 8'hFF;
    // programming time
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_MIN_NS = 3_200_000;
    localparam int PROG_MAX_NS = 3_400_000;
    localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic intEnable;
        logic sectionBusy;
        logic reserved;
        logic sectionReenable;
        logic lockSet;
        logic pageWrite;
        logic pageErase;
        logic commandEnable;
    } fsp_ctrl_type;

    typedef struct packed {
        logic eraseStart;
        logic writeStart;
        logic [PAGE_BITS-1:0] page;
    } fsp_flash_op_type;

    typedef enum {SEQ_IDLE, SEQ_ARMED, SEQ_RUN} fsp_seq_type;
endpackage

// File: hdl/fsp_prog_timer.sv
// Purpose: programming-time counter for erase, write and lock operations
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses in the cycle the count expires
`timescale 1ns/1ps
`default_nettype none
module fsp_prog_timer #(
    parameter int CYCLES = fsp_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // control
    input wire logic start,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
    logic [CW-1:0] count;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= '0;
            busy <= 1'b0;
        end else if (start && !busy) begin
            count <= LOAD;
            busy <= 1'b1;
        end else if (busy) begin
            if (count == '0) begin
                busy <= 1'b0;
            end else begin
                count <= count - CW'(1);
            end
        end
    end

    assign done = busy && (count == '0);
endmodule // fsp_prog_timer
`default_nettype wire

// File: hdl/fsp_sequencer.sv
// Purpose: flash self-program sequencer: arming, erase, load, write, locks, fuse reads
// Assumes: cpu strobes are one cycle and synchronous to mclk; flash read data follows flashRdAddr combinationally
// Notes: lock bits live here as a programmed mask over their strapped values
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - erase: pattern then store within four cycles
// - erase ignores data and non-page pointer bits
// - erase to protected section halts cpu
// - load pattern stores word at Z5:Z1
// - buffer clears after write, re-enable, reset
// - eeprom write discards loaded buffer words
// - write pattern, page field selects page
// - write to protected section halts cpu
// - target page latched at operation start
// - load instruction selects byte by Z0
// - interrupt held while enabled and idle
// - busy section blocked, busy flag set
// - busy flag cleared only by re-enable
// - lock programming: zero data bits program locks
// - lock programming keeps whole flash readable
// - eeprom write blocks commands and fuse reads
// - lock byte read within three cycles
// - lock-set and enable auto-clear after window
// - fuse low, high, extended by pointer
// - programmed bits read zero, unprogrammed one
// - operations last 3.2 to 3.4 ms
module fsp_sequencer #(
    parameter int PROG_CYCLES = fsp_pkg::PROG_CYCLES,
    parameter logic [fsp_pkg::PAGE_BITS-1:0] HALT_FIRST_PAGE = 10'h3C0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // cpu instruction side
    input wire logic spmStrobe,
    input wire logic lpmStrobe,
    input wire logic [15:0] zPointer,
    input wire logic [15:0] dataWordPair,
    output logic [7:0] lpmData,
    output logic lpmValid,
    output logic cpuHalt,
    output logic spmIrq,
    // flash array side
    output logic [14:0] flashRdAddr,
    input wire logic [15:0] flashRdData,
    output fsp_pkg::fsp_flash_op_type flashOp,
    input wire logic [fsp_pkg::WORD_BITS-1:0] bufRdIndex,
    output logic [15:0] bufRdData,
    output logic appReadBlock,
    // eeprom, fuses and lock straps
    input wire logic eepromWriteActive,
    input wire logic [7:0] fuseLowByte,
    input wire logic [7:0] fuseHighByte,
    input wire logic [7:0] fuseExtendedByte,
    input wire logic [5:0] lockStrap
);
    localparam int WB = fsp_pkg::WORD_BITS;
    localparam int PB = fsp_pkg::PAGE_BITS;

    fsp_pkg::fsp_ctrl_type ctrl;
    fsp_pkg::fsp_seq_type seqState;
    logic [2:0] armAge;
    logic [PB-1:0] opPage;
    logic opErase;
    logic opWrite;
    logic opLock;
    logic [5:0] opLockData;
    logic [5:0] lockProgrammed;
    logic eepromSeen;
    logic bufferDirty;
    logic timerBusy;
    logic timerDone;

    // decoded strobes
    logic ctrlWrite;
    logic [4:0] armCmd;
    logic armAccept;
    logic storeInWindow;
    logic loadInWindow;
    logic storeHit;
    logic fuseReadHit;
    logic windowExpired;
    logic startErase;
    logic startWrite;
    logic startLock;
    logic doLoad;
    logic doReenable;
    logic bufClear;
    logic eepromRise;
    logic [PB-1:0] zPage;
    logic [7:0] lockByte;
    logic [7:0] fuseByte;
    logic [7:0] flashByte;
    logic lpmToApp;

    assign ctrlWrite = regWrite && (regAddr == fsp_pkg::CTRL_OFFSET);
    assign armCmd = regWdata[4:0] & fsp_pkg::CMD_MASK;
    // commands are refused while an eeprom write runs
    assign armAccept = ctrlWrite && (seqState == fsp_pkg::SEQ_IDLE) && !eepromWriteActive
        && armCmd[0];
    assign storeInWindow = (seqState == fsp_pkg::SEQ_ARMED)
        && (armAge <= fsp_pkg::STORE_WINDOW);
    assign loadInWindow = (seqState == fsp_pkg::SEQ_ARMED)
        && (armAge <= fsp_pkg::LOAD_WINDOW);
    assign storeHit = spmStrobe && storeInWindow && !eepromWriteActive;
    assign fuseReadHit = lpmStrobe && loadInWindow && ctrl.lockSet
        && !eepromWriteActive;
    assign windowExpired = (seqState == fsp_pkg::SEQ_ARMED) && (armAge == fsp_pkg::STORE_WINDOW)
        && !storeHit && !fuseReadHit;
    assign zPage = zPointer[fsp_pkg::PAGE_LSB +: PB];

    always_comb begin
        startErase = 1'b0;
        startWrite = 1'b0;
        startLock = 1'b0;
        doLoad = 1'b0;
        doReenable = 1'b0;
        if (storeHit) begin
            case ({ctrl.sectionReenable, ctrl.lockSet, ctrl.pageWrite, ctrl.pageErase, ctrl.commandEnable})
                fsp_pkg::CMD_ERASE: startErase = 1'b1;
                fsp_pkg::CMD_WRITE: startWrite = 1'b1;
                fsp_pkg::CMD_LOCK: startLock = 1'b1;
                fsp_pkg::CMD_LOAD: doLoad = 1'b1;
                fsp_pkg::CMD_REENABLE: doReenable = 1'b1;
                default: doLoad = 1'b0;
            endcase
        end
    end

    // sequencer state and arming age
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seqState <= fsp_pkg::SEQ_IDLE;
            armAge <= '0;
        end else begin
            case (seqState)
                fsp_pkg::SEQ_IDLE: begin
                    armAge <= 3'h1;
                    if (armAccept) begin
                        seqState <= fsp_pkg::SEQ_ARMED;
                    end
                end
                fsp_pkg::SEQ_ARMED: begin
                    armAge <= armAge + 3'h1;
                    if (startErase || startWrite || startLock) begin
                        seqState <= fsp_pkg::SEQ_RUN;
                    end else if (storeHit || fuseReadHit || windowExpired) begin
                        seqState <= fsp_pkg::SEQ_IDLE;
                    end
                end
                fsp_pkg::SEQ_RUN: begin
                    if (timerDone) begin
                        seqState <= fsp_pkg::SEQ_IDLE;
                    end
                end
                default: seqState <= fsp_pkg::SEQ_IDLE;
            endcase
        end
    end

    // control register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= fsp_pkg::fsp_ctrl_type'(fsp_pkg::CTRL_RESET);
        end else begin
            if (ctrlWrite) begin
                ctrl.intEnable <= regWdata[7];
            end
            if (armAccept) begin
                ctrl.commandEnable <= 1'b1;
                ctrl.pageErase <= armCmd[1];
                ctrl.pageWrite <= armCmd[2];
                ctrl.lockSet <= armCmd[3];
                ctrl.sectionReenable <= armCmd[4];
            end else if ((seqState == fsp_pkg::SEQ_ARMED && !startErase && !startWrite && !startLock
                && (storeHit || fuseReadHit || windowExpired)) || timerDone) begin
                ctrl.commandEnable <= 1'b0;
                ctrl.pageErase <= 1'b0;
                ctrl.pageWrite <= 1'b0;
                ctrl.lockSet <= 1'b0;
                ctrl.sectionReenable <= 1'b0;
            end
            // a fresh erase or write outranks a re-enable in the same cycle
            if (startErase || startWrite) begin
                ctrl.sectionBusy <= 1'b1;
            end else if (doReenable && !timerBusy) begin
                ctrl.sectionBusy <= 1'b0;
            end
            ctrl.reserved <= 1'b0;
        end
    end

    // operation latch, immune to later pointer changes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            opPage <= '0;
            opErase <= 1'b0;
            opWrite <= 1'b0;
            opLock <= 1'b0;
            opLockData <= '0;
        end else if (startErase || startWrite || startLock) begin
            opPage <= zPage;
            opErase <= startErase;
            opWrite <= startWrite;
            opLock <= startLock;
            opLockData <= dataWordPair[5:0];
        end else if (timerDone) begin
            opErase <= 1'b0;
            opWrite <= 1'b0;
            opLock <= 1'b0;
        end
    end

    fsp_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_fsp_prog_timer (
        .mclk(mclk),
        .rst(rst),
        .start(startErase || startWrite || startLock),
        .busy(timerBusy),
        .done(timerDone)
    );

    // lock programming takes effect when its time has run out
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lockProgrammed <= fsp_pkg::LOCK_CLEAR_MASK;
        end else if (timerDone && opLock) begin
            lockProgrammed <= lockProgrammed | ~opLockData;
        end
    end

    // flash array commands, one-cycle start pulses
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flashOp <= '0;
        end else begin
            flashOp.eraseStart <= startErase;
            flashOp.writeStart <= startWrite;
            if (startErase || startWrite) begin
                flashOp.page <= zPage;
            end
        end
    end

    // eeprom write onset discards a partly loaded page
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            eepromSeen <= 1'b0;
            bufferDirty <= 1'b0;
        end else begin
            eepromSeen <= eepromWriteActive;
            if (doLoad) begin
                bufferDirty <= 1'b1;
            end else if (bufClear) begin
                bufferDirty <= 1'b0;
            end
        end
    end

    assign eepromRise = eepromWriteActive && !eepromSeen;
    assign bufClear = (timerDone && opWrite) || doReenable
        || (eepromRise && bufferDirty);

    fsp_page_buffer #(
        .WORDS(1 << WB),
        .WIDTH(16)
    ) u_fsp_page_buffer (
        .mclk(mclk),
        .rst(rst),
        .wrEn(doLoad),
        .wrIndex(zPointer[fsp_pkg::WORD_LSB +: WB]),
        .wrData(dataWordPair),
        .clear(bufClear),
        .rdIndex(bufRdIndex),
        .rdData(bufRdData)
    );

    // read path: fuse and lock bytes, else flash bytes
    assign lockByte = {fsp_pkg::LOCK_TOP_BITS, lockStrap & ~lockProgrammed};
    assign flashRdAddr = zPointer[15:1];
    assign flashByte = zPointer[0] ? flashRdData[15:8] : flashRdData[7:0];
    assign lpmToApp = (zPage < HALT_FIRST_PAGE) && appReadBlock;

    always_comb begin
        case (zPointer)
            fsp_pkg::Z_FUSE_LOW: fuseByte = fuseLowByte;
            fsp_pkg::Z_LOCK: fuseByte = lockByte;
            fsp_pkg::Z_FUSE_EXT: fuseByte = fuseExtendedByte;
            fsp_pkg::Z_FUSE_HIGH: fuseByte = fuseHighByte;
            default: fuseByte = fsp_pkg::BLOCKED_BYTE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lpmData <= '0;
            lpmValid <= 1'b0;
        end else begin
            lpmValid <= lpmStrobe;
            if (lpmStrobe) begin
                if (fuseReadHit) begin
                    lpmData <= fuseByte;
                end else if (lpmToApp) begin
                    lpmData <= fsp_pkg::BLOCKED_BYTE;
                end else begin
                    lpmData <= flashByte;
                end
            end
        end
    end

    // register read, one cycle later
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= (regAddr == fsp_pkg::CTRL_OFFSET) ? ctrl : 8'h00;
        end else begin
            regRdata <= '0;
        end
    end

    // halts and blocks; lock programming neither halts nor blocks
    assign cpuHalt = timerBusy && (opErase || opWrite) && (opPage >= HALT_FIRST_PAGE);
    assign appReadBlock = ctrl.sectionBusy;
    assign spmIrq = ctrl.intEnable && !ctrl.commandEnable;
endmodule // fsp_sequencer
`default_nettype wire

// File: tb/fsp_cpu_model.sv
// Purpose: cpu-side model issuing register, store and load accesses
// Assumes: each task is entered just after a rising mclk edge
// Notes: data lines show the inverse once released
`timescale 1ns/1ps
`default_nettype none
module fsp_cpu_model (
    // clock
    input wire logic mclk,
    // register port
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    output logic regWrite,
    output logic regRead,
    input wire logic [7:0] regRdata,
    // instruction side
    output logic spmStrobe,
    output logic lpmStrobe,
    output logic [15:0] zPointer,
    output logic [15:0] dataWordPair,
    input wire logic [7:0] lpmData
);
    initial begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        spmStrobe = 1'b0;
        lpmStrobe = 1'b0;
        zPointer = 16'h0000;
        dataWordPair = 16'h0000;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regWdata <= ~d;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic spm(input logic [15:0] z, input logic [15:0] d);
        zPointer <= z;
        dataWordPair <= d;
        spmStrobe <= 1'b1;
        @(posedge mclk);
        spmStrobe <= 1'b0;
        dataWordPair <= ~d;
        #1;
    endtask
    task automatic lpm(input logic [15:0] z, output logic [7:0] b);
        zPointer <= z;
        lpmStrobe <= 1'b1;
        @(posedge mclk);
        lpmStrobe <= 1'b0;
        #1;
        b = lpmData;
    endtask
endmodule // fsp_cpu_model
`default_nettype wire

// File: tb/fsp_sequencer_sva.sv
// Purpose: port assertions of the flash self-program sequencer
// Assumes: one mclk domain, bound to fsp_sequencer
// Notes: operation length is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module fsp_sequencer_sva #(
    parameter logic [fsp_pkg::PAGE_BITS-1:0] HALT_FIRST_PAGE = 10'h3C0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // cpu side
    input wire logic spmStrobe,
    input wire logic lpmStrobe,
    input wire logic [15:0] zPointer,
    input wire logic lpmValid,
    input wire logic [7:0] lpmData,
    input wire logic cpuHalt,
    input wire logic spmIrq,
    // flash side
    input wire fsp_pkg::fsp_flash_op_type flashOp,
    input wire logic appReadBlock,
    input wire logic eepromWriteActive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic opStart;
    assign opStart = flashOp.eraseStart | flashOp.writeStart;
    sequence s_accept;
        spmStrobe ##1 opStart;
    endsequence
    property p_startCause;
        opStart |-> $past(spmStrobe);
    endproperty
    property p_startPulse;
        opStart |=> !opStart;
    endproperty
    property p_pageHold;
        !opStart |-> $stable(flashOp.page);
    endproperty
    property p_busyHeld;
        opStart |-> appReadBlock[*8];
    endproperty
    property p_irqLow;
        s_accept |-> !spmIrq[*8];
    endproperty
    property p_halt;
        cpuHalt |-> appReadBlock && !spmIrq;
    endproperty
    property p_eeBlock;
        eepromWriteActive && spmStrobe |=> !opStart;
    endproperty
    property p_appRead;
        lpmStrobe && appReadBlock && zPointer[15:6] < HALT_FIRST_PAGE && zPointer > 16'h0003 |=> lpmData == 8'hFF;
    endproperty
    property p_lpmAnswer;
        lpmStrobe |=> lpmValid;
    endproperty
    a_startCause: assert property (p_startCause) else $error("start without store");
    a_startPulse: assert property (p_startPulse) else $error("start longer than one cycle");
    a_pageHold: assert property (p_pageHold) else $error("page moved without start");
    a_busyHeld: assert property (p_busyHeld) else $error("busy flag dropped");
    a_irqLow: assert property (p_irqLow) else $error("irq during operation");
    a_halt: assert property (p_halt) else $error("halt outside busy operation");
    a_eeBlock: assert property (p_eeBlock) else $error("command during eeprom write");
    a_appRead: assert property (p_appRead) else $error("busy section readable");
    a_lpmAnswer: assert property (p_lpmAnswer) else $error("load not answered");
endmodule // fsp_sequencer_sva
bind fsp_sequencer fsp_sequencer_sva #(.HALT_FIRST_PAGE(HALT_FIRST_PAGE)) u_fsp_sequencer_sva (
    .mclk(mclk), .rst(rst), .spmStrobe(spmStrobe), .lpmStrobe(lpmStrobe), .zPointer(zPointer),
    .lpmValid(lpmValid), .lpmData(lpmData), .cpuHalt(cpuHalt), .spmIrq(spmIrq), .flashOp(flashOp),
    .appReadBlock(appReadBlock), .eepromWriteActive(eepromWriteActive)
);
`default_nettype wire

// File: tb/tb_fsp_sequencer.sv
// Purpose: self-checking bench of the flash self-program sequencer
// Assumes: PROG_CYCLES shortened to 20
// Notes: flash array is a pattern of its read address
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin numErrors++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_fsp_sequencer;
    localparam int PC = 20;
    localparam logic [7:0] FLO = 8'h62;
    localparam logic [7:0] FHI = 8'hD9;
    localparam logic [7:0] FEX = 8'hF7;
    localparam logic [5:0] LSTRAP = 6'h37;
    logic mclk, rst, regWrite, regRead, spmStrobe, lpmStrobe, lpmValid, cpuHalt, spmIrq;
    logic appReadBlock, eepromWriteActive;
    logic [7:0] regAddr, regWdata, regRdata, lpmData, b;
    logic [15:0] zPointer, dataWordPair, flashRdData, bufRdData;
    logic [14:0] flashRdAddr;
    logic [4:0] bufRdIndex;
    fsp_pkg::fsp_flash_op_type flashOp;
    int numErrors = 0;
    int testsRun = 0;
    int cycles = 0;
    assign flashRdData = {flashRdAddr[7:0], ~flashRdAddr[7:0]};
    fsp_sequencer #(.PROG_CYCLES(PC)) u_fsp_sequencer (
        .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .spmStrobe(spmStrobe), .lpmStrobe(lpmStrobe),
        .zPointer(zPointer), .dataWordPair(dataWordPair), .lpmData(lpmData), .lpmValid(lpmValid),
        .cpuHalt(cpuHalt), .spmIrq(spmIrq), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .flashOp(flashOp), .bufRdIndex(bufRdIndex), .bufRdData(bufRdData), .appReadBlock(appReadBlock),
        .eepromWriteActive(eepromWriteActive), .fuseLowByte(FLO), .fuseHighByte(FHI),
        .fuseExtendedByte(FEX), .lockStrap(LSTRAP)
    );
    fsp_cpu_model u_fsp_cpu_model (
        .mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .spmStrobe(spmStrobe), .lpmStrobe(lpmStrobe), .zPointer(zPointer),
        .dataWordPair(dataWordPair), .lpmData(lpmData)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic bufIs(input logic [4:0] i, input logic [15:0] e);
        bufRdIndex <= i;
        #1;
        `CHK("buffer word", e, bufRdData)
    endtask
    task automatic ctrlIs(input logic [7:0] e);
        u_fsp_cpu_model.rd(8'h00, b);
        `CHK("control", e, b)
    endtask
    task automatic t_reset();
        u_fsp_cpu_model.rd(8'h5A, b);
        `CHK("unmapped", 8'h00, b)
        ctrlIs(8'h00);
        for (int i = 0; i < 32; i++) bufIs(i[4:0], 16'hFFFF);
        $display("reset test done");
    endtask
    task automatic t_load();
        u_fsp_cpu_model.wr(8'h00, 8'h01);
        u_fsp_cpu_model.spm(16'hFFC1, 16'h1234);
        u_fsp_cpu_model.wr(8'h00, 8'h01);
        cyc(3);
        u_fsp_cpu_model.spm(16'h003E, 16'hA55A);
        u_fsp_cpu_model.wr(8'h00, 8'h01);
        cyc(4);
        u_fsp_cpu_model.spm(16'h0004, 16'h0BAD);
        bufIs(5'h00, 16'h1234);
        bufIs(5'h1F, 16'hA55A);
        bufIs(5'h02, 16'hFFFF);
        ctrlIs(8'h00);
        $display("load test done");
    endtask
    task automatic t_erase();
        time t0;
        int len;
        u_fsp_cpu_model.wr(8'h00, 8'h83);
        u_fsp_cpu_model.spm(16'h0A7F, 16'hDEAD);
        t0 = $time;
        `CHK("erase start", 1'b1, flashOp.eraseStart)
        `CHK("erase page", 10'h029, flashOp.page)
        `CHK("halt", 1'b0, cpuHalt)
        u_fsp_cpu_model.lpm(16'h0100, b);
        `CHK("blocked byte", 8'hFF, b)
        u_fsp_cpu_model.lpm(16'hF0A5, b);
        `CHK("readable byte", 8'h52, b)
        `CHK("latched page", 10'h029, flashOp.page)
        ctrlIs(8'hC3);
        len = 0;
        while (spmIrq !== 1'b1 && len < 200) begin
            cyc(1);
            len++;
        end
        len = int'(($time - t0) / 10);
        `CHK("op length", 1'b1, len >= PC && len <= PC + 3)
        ctrlIs(8'hC0);
        u_fsp_cpu_model.wr(8'h00, 8'h91);
        u_fsp_cpu_model.spm(16'h0000, 16'h0000);
        cyc(2);
        ctrlIs(8'h80);
        bufIs(5'h00, 16'hFFFF);
        $display("erase test done");
    endtask
    task automatic t_write();
        int n;
        u_fsp_cpu_model.wr(8'h00, 8'h01);
        u_fsp_cpu_model.spm(16'h0002, 16'h7777);
        bufIs(5'h01, 16'h7777);
        u_fsp_cpu_model.wr(8'h00, 8'h05);
        u_fsp_cpu_model.spm(16'hF000, 16'h1111);
        `CHK("write start", 1'b1, flashOp.writeStart)
        `CHK("write page", 10'h3C0, flashOp.page)
        `CHK("halt", 1'b1, cpuHalt)
        for (n = 0; n < 200 && cpuHalt === 1'b1; n++) cyc(1);
        `CHK("halt length", PC, n)
        cyc(2);
        bufIs(5'h01, 16'hFFFF);
        u_fsp_cpu_model.wr(8'h00, 8'h11);
        u_fsp_cpu_model.spm(16'h0000, 16'h0000);
        cyc(2);
        $display("write test done");
    endtask
    task automatic t_lock();
        u_fsp_cpu_model.wr(8'h00, 8'h09);
        u_fsp_cpu_model.spm(16'h0001, 16'h00F5);
        cyc(3);
        `CHK("lock busy", 1'b0, appReadBlock)
        `CHK("lock halt", 1'b0, cpuHalt)
        cyc(PC + 3);
        u_fsp_cpu_model.wr(8'h00, 8'h09);
        u_fsp_cpu_model.lpm(16'h0001, b);
        `CHK("lock byte", {2'b11, LSTRAP & ~6'h0A}, b)
        ctrlIs(8'h00);
        u_fsp_cpu_model.lpm(16'h0001, b);
        `CHK("plain byte", 8'h00, b)
        $display("lock test done");
    endtask
    task automatic t_fuse();
        logic [15:0] z[3] = '{16'h0000, 16'h0003, 16'h0002};
        logic [7:0] e[3] = '{FLO, FHI, FEX};
        for (int i = 0; i < 3; i++) begin
            u_fsp_cpu_model.wr(8'h00, 8'h09);
            cyc(i);
            u_fsp_cpu_model.lpm(z[i], b);
            `CHK("fuse byte", e[i], b)
        end
        u_fsp_cpu_model.wr(8'h00, 8'h09);
        cyc(3);
        u_fsp_cpu_model.lpm(16'h0000, b);
        `CHK("late fuse read", 8'hFF, b)
        $display("fuse test done");
    endtask
    task automatic t_eeprom();
        u_fsp_cpu_model.wr(8'h00, 8'h01);
        u_fsp_cpu_model.spm(16'h0006, 16'h4321);
        bufIs(5'h03, 16'h4321);
        eepromWriteActive <= 1'b1;
        cyc(2);
        bufIs(5'h03, 16'hFFFF);
        u_fsp_cpu_model.wr(8'h00, 8'h03);
        u_fsp_cpu_model.spm(16'h0100, 16'h0000);
        `CHK("blocked erase", 1'b0, flashOp.eraseStart)
        u_fsp_cpu_model.wr(8'h00, 8'h09);
        u_fsp_cpu_model.lpm(16'h0000, b);
        `CHK("blocked fuse", 8'hFF, b)
        eepromWriteActive <= 1'b0;
        $display("eeprom test done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            numErrors++;
            results();
        end
    end
    initial begin
        rst = 1'b1;
        bufRdIndex = 5'h00;
        eepromWriteActive = 1'b0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_load();
        t_erase();
        t_write();
        t_lock();
        t_fuse();
        t_eeprom();
        results();
    end
endmodule // tb_fsp_sequencer
`default_nettype wire
